// ===== common/legacy_exec_pkg.sv
// constants and types of the legacy control-transfer executor
// assumes a 10 MHz core clock and a classic wishbone register port
package legacy_exec_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_SP = 8'h08;
  localparam logic [7:0] OFS_ACC_LOW = 8'h0c;
  localparam logic [7:0] OFS_REPEAT_COUNT_REG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [2:0] OFS_XAR_BLOCK = 3'h1;
  // control and status fields
  localparam int CTRL_OBJECT_MODE_BIT_BIT = 0;
  localparam int CTRL_ARMED_BIT = 1;
  localparam int CTRL_ARP_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_UNKNOWN_BIT = 2;
  // reset values
  localparam logic [21:0] PC_RESET = 22'h3f0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] REPEAT_COUNT_REG_RESET = 8'h00;
  localparam logic [5:0] PC_PAGE = 6'h3f;
  // opcodes
  localparam logic [15:0] OP_BANZ_IND = 16'h560c;
  localparam logic [15:0] OP_BANZ_INC = 16'h560a;
  localparam logic [15:0] OP_BANZ_DEC = 16'h560b;
  localparam logic [15:0] OP_BANZ_IDX_INC = 16'h560e;
  localparam logic [15:0] OP_BANZ_IDX_DEC = 16'h560f;
  localparam logic [15:0] OP_CALL_ACC = 16'h5634;
  localparam logic [15:0] OP_BANZ_IND_ARP = 16'h3c70;
  localparam logic [15:0] OP_BANZ_INC_ARP = 16'h3e78;
  localparam logic [15:0] OP_BANZ_DEC_ARP = 16'h3e40;
  localparam logic [15:0] OP_BANZ_IDXI_ARP = 16'h3e48;
  localparam logic [15:0] OP_BANZ_IDXD_ARP = 16'h3e50;
  localparam logic [15:0] OP_CALL_IMM_ARP = 16'h3e68;
  localparam logic [15:0] ARP_FIELD_MASK = 16'hfff8;
  // execute cycle counts
  localparam logic [2:0] CYC_BANZ_TAKEN = 3'h4;
  localparam logic [2:0] CYC_BANZ_NOT = 3'h2;
  localparam logic [2:0] CYC_CALL_ACC = 3'h7;
  localparam logic [2:0] CYC_CALL_IMM = 3'h4;

  typedef enum logic [2:0] {
    MOD_NONE, MOD_INC, MOD_DEC, MOD_IDX_INC, MOD_IDX_DEC
  } post_mod_e;

  typedef enum logic [1:0] {
    KIND_BANZ, KIND_CALL_ACC, KIND_CALL_IMM
  } op_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b11
  } exec_state_e;
endpackage

// ===== hw/aux_reg_file.sv
// bank of extended auxiliary registers held in flip-flops
// assumes modify and bus write never target one entry together
`timescale 1ns/10ps
`default_nettype none
module aux_reg_file #(
  parameter int COUNT = 8,
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_we,
  input wire logic [$clog2(COUNT)-1:0] bus_idx,
  input wire logic [WIDTH-1:0] bus_data,
  input wire logic mod_en,
  input wire logic [$clog2(COUNT)-1:0] mod_idx,
  input wire logic [WIDTH-1:0] mod_value,
  output logic [COUNT*WIDTH-1:0] regs_flat
);
  generate
    if (COUNT < 2 || WIDTH < 16)
    begin : g_bad
      $error("aux_reg_file: unsupported size");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < COUNT; i++)
    begin : g_entry
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          regs_flat[i*WIDTH +: WIDTH] <= '0;
        end
        else if (mod_en && mod_idx == i)
        begin
          regs_flat[i*WIDTH +: WIDTH] <= mod_value;
        end
        else if (bus_we && bus_idx == i)
        begin
          regs_flat[i*WIDTH +: WIDTH] <= bus_data;
        end
      end
    end
  endgenerate
endmodule // aux_reg_file
`default_nettype wire

// ===== hw/legacy_branch_call_exec.sv
// executor for the legacy branch-on-aux and call instructions
// assumes a 16-bit word stream and classic wishbone register access
`timescale 1ns/10ps
`default_nettype none
module legacy_branch_call_exec #(
  parameter int AUX_COUNT = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  output logic word_ready,
  output logic stack_we,
  output logic [15:0] stack_addr,
  output logic [15:0] stack_data,
  output logic [21:0] pc_out,
  output logic exec_done
);
  generate
    if (AUX_COUNT != 8)
    begin : g_bad
      $error("legacy_branch_call_exec: pointer field selects exactly 8");
    end
  endgenerate

  legacy_exec_pkg::exec_state_e state_reg;
  legacy_exec_pkg::op_kind_e kind_reg;
  legacy_exec_pkg::post_mod_e mod_reg;
  logic arp_load_reg;
  logic [2:0] arp_new_reg;
  logic [15:0] imm_reg;
  logic [2:0] cnt_reg;
  logic taken_reg;
  logic object_mode_bit_reg;
  logic armed_reg;
  logic [2:0] arp_reg;
  logic [21:0] pc_reg;
  logic [15:0] sp_reg;
  logic [15:0] acc_low_reg;
  logic [7:0] repeat_count_reg_reg;
  logic unknown_reg;
  logic [AUX_COUNT*32-1:0] xar_flat;

  // decode results
  logic dec_hit;
  legacy_exec_pkg::op_kind_e dec_kind;
  legacy_exec_pkg::post_mod_e dec_mod;
  logic dec_two;
  logic dec_arp_load;

  // bus decode
  logic bus_req;
  logic bus_wr;
  logic busy;
  logic bus_wr_ok;
  logic xar_hit;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic [31:0] rd_word;

  // execution helpers
  logic word_take;
  logic last_cycle;
  logic [31:0] xar_sel;
  logic [31:0] idx_ext;
  logic [31:0] xar_mod;
  logic [21:0] ret_addr;
  logic [21:0] pc_commit;
  logic mod_en;

  function automatic logic [31:0] merge_sel(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // instruction decode, gated by object mode
  always_comb
  begin
    dec_hit = 1'b1;
    dec_kind = legacy_exec_pkg::KIND_BANZ;
    dec_mod = legacy_exec_pkg::MOD_NONE;
    dec_two = 1'b1;
    dec_arp_load = 1'b0;
    case (word_data)
      legacy_exec_pkg::OP_BANZ_IND: dec_mod = legacy_exec_pkg::MOD_NONE;
      legacy_exec_pkg::OP_BANZ_INC: dec_mod = legacy_exec_pkg::MOD_INC;
      legacy_exec_pkg::OP_BANZ_DEC: dec_mod = legacy_exec_pkg::MOD_DEC;
      legacy_exec_pkg::OP_BANZ_IDX_INC: dec_mod = legacy_exec_pkg::MOD_IDX_INC;
      legacy_exec_pkg::OP_BANZ_IDX_DEC: dec_mod = legacy_exec_pkg::MOD_IDX_DEC;
      legacy_exec_pkg::OP_CALL_ACC:
      begin
        dec_kind = legacy_exec_pkg::KIND_CALL_ACC;
        dec_two = 1'b0;
      end
      default:
      begin
        dec_arp_load = 1'b1;
        case (word_data & legacy_exec_pkg::ARP_FIELD_MASK)
          legacy_exec_pkg::OP_BANZ_IND_ARP: dec_mod = legacy_exec_pkg::MOD_NONE;
          legacy_exec_pkg::OP_BANZ_INC_ARP: dec_mod = legacy_exec_pkg::MOD_INC;
          legacy_exec_pkg::OP_BANZ_DEC_ARP: dec_mod = legacy_exec_pkg::MOD_DEC;
          legacy_exec_pkg::OP_BANZ_IDXI_ARP: dec_mod = legacy_exec_pkg::MOD_IDX_INC;
          legacy_exec_pkg::OP_BANZ_IDXD_ARP: dec_mod = legacy_exec_pkg::MOD_IDX_DEC;
          legacy_exec_pkg::OP_CALL_IMM_ARP: dec_kind = legacy_exec_pkg::KIND_CALL_IMM;
          default:
          begin
            dec_hit = 1'b0;
            dec_arp_load = 1'b0;
          end
        endcase
      end
    endcase
    if (!object_mode_bit_reg)
    begin
      dec_hit = 1'b0;
    end
  end

  assign word_take = word_valid && word_ready;
  assign busy = state_reg != legacy_exec_pkg::ST_IDLE;
  assign last_cycle = state_reg == legacy_exec_pkg::ST_EXEC && cnt_reg == 3'h1;
  assign xar_sel = xar_flat[arp_reg*32 +: 32];
  assign idx_ext = {16'h0000, xar_flat[15:0]};
  assign ret_addr = pc_reg + 22'h000001;

  // post-modify value of the selected register
  always_comb
  begin
    case (mod_reg)
      legacy_exec_pkg::MOD_INC: xar_mod = xar_sel + 32'h00000001;
      legacy_exec_pkg::MOD_DEC: xar_mod = xar_sel - 32'h00000001;
      legacy_exec_pkg::MOD_IDX_INC: xar_mod = xar_sel + idx_ext;
      legacy_exec_pkg::MOD_IDX_DEC: xar_mod = xar_sel - idx_ext;
      default: xar_mod = xar_sel;
    endcase
  end

  assign mod_en = last_cycle && kind_reg == legacy_exec_pkg::KIND_BANZ;

  // program counter at completion
  always_comb
  begin
    case (kind_reg)
      legacy_exec_pkg::KIND_CALL_ACC:
        pc_commit = {legacy_exec_pkg::PC_PAGE, acc_low_reg};
      legacy_exec_pkg::KIND_CALL_IMM:
        pc_commit = {legacy_exec_pkg::PC_PAGE, imm_reg};
      default:
        pc_commit = taken_reg ? {legacy_exec_pkg::PC_PAGE, imm_reg}
                              : pc_reg + 22'h000002;
    endcase
  end

  // sequencer: opcode, optional immediate word, counted execute
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= legacy_exec_pkg::ST_IDLE;
      word_ready <= 1'b0;
      cnt_reg <= 3'h0;
      taken_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        legacy_exec_pkg::ST_IDLE:
        begin
          word_ready <= 1'b1;
          if (word_take && dec_hit)
          begin
            if (dec_two)
            begin
              state_reg <= legacy_exec_pkg::ST_FETCH;
            end
            else
            begin
              state_reg <= legacy_exec_pkg::ST_EXEC;
              word_ready <= 1'b0;
              cnt_reg <= legacy_exec_pkg::CYC_CALL_ACC;
            end
          end
        end
        legacy_exec_pkg::ST_FETCH:
        begin
          if (word_take)
          begin
            state_reg <= legacy_exec_pkg::ST_EXEC;
            word_ready <= 1'b0;
            if (kind_reg == legacy_exec_pkg::KIND_CALL_IMM)
            begin
              cnt_reg <= legacy_exec_pkg::CYC_CALL_IMM;
            end
            else if (xar_sel[15:0] != 16'h0000)
            begin
              taken_reg <= 1'b1;
              cnt_reg <= legacy_exec_pkg::CYC_BANZ_TAKEN;
            end
            else
            begin
              taken_reg <= 1'b0;
              cnt_reg <= legacy_exec_pkg::CYC_BANZ_NOT;
            end
          end
        end
        legacy_exec_pkg::ST_EXEC:
        begin
          cnt_reg <= cnt_reg - 3'h1;
          if (last_cycle)
          begin
            state_reg <= legacy_exec_pkg::ST_IDLE;
            word_ready <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= legacy_exec_pkg::ST_IDLE;
          word_ready <= 1'b0;
        end
      endcase
    end
  end

  // latched instruction fields
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kind_reg <= legacy_exec_pkg::KIND_BANZ;
      mod_reg <= legacy_exec_pkg::MOD_NONE;
      arp_load_reg <= 1'b0;
      arp_new_reg <= 3'h0;
      imm_reg <= 16'h0000;
    end
    else if (word_take)
    begin
      if (state_reg == legacy_exec_pkg::ST_IDLE && dec_hit)
      begin
        kind_reg <= dec_kind;
        mod_reg <= dec_mod;
        arp_load_reg <= dec_arp_load;
        arp_new_reg <= word_data[2:0];
      end
      else if (state_reg == legacy_exec_pkg::ST_FETCH)
      begin
        imm_reg <= word_data;
      end
    end
  end

  // completion pulse and stack push
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      exec_done <= 1'b0;
      stack_we <= 1'b0;
      stack_addr <= 16'h0000;
      stack_data <= 16'h0000;
    end
    else
    begin
      exec_done <= last_cycle;
      stack_we <= last_cycle && kind_reg != legacy_exec_pkg::KIND_BANZ;
      if (last_cycle && kind_reg != legacy_exec_pkg::KIND_BANZ)
      begin
        stack_addr <= sp_reg;
        stack_data <= ret_addr[15:0];
      end
    end
  end

  // bus request and write gating
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign bus_wr_ok = bus_wr && !busy;
  assign xar_hit = wb_adr_i[7:5] == legacy_exec_pkg::OFS_XAR_BLOCK;

  always_comb
  begin
    cur_word = 32'h00000000;
    if (xar_hit)
    begin
      cur_word = xar_flat[wb_adr_i[4:2]*32 +: 32];
    end
    else
    begin
      case (wb_adr_i)
        legacy_exec_pkg::OFS_CTRL:
        begin
          cur_word[legacy_exec_pkg::CTRL_OBJECT_MODE_BIT_BIT] = object_mode_bit_reg;
          cur_word[legacy_exec_pkg::CTRL_ARMED_BIT] = armed_reg;
          cur_word[legacy_exec_pkg::CTRL_ARP_LSB +: 3] = arp_reg;
        end
        legacy_exec_pkg::OFS_PC: cur_word[21:0] = pc_reg;
        legacy_exec_pkg::OFS_SP: cur_word[15:0] = sp_reg;
        legacy_exec_pkg::OFS_ACC_LOW: cur_word[15:0] = acc_low_reg;
        legacy_exec_pkg::OFS_REPEAT_COUNT_REG: cur_word[7:0] = repeat_count_reg_reg;
        legacy_exec_pkg::OFS_STATUS:
        begin
          cur_word[legacy_exec_pkg::STAT_BUSY_BIT] = busy;
          cur_word[legacy_exec_pkg::STAT_TAKEN_BIT] = taken_reg;
          cur_word[legacy_exec_pkg::STAT_UNKNOWN_BIT] = unknown_reg;
        end
        default: cur_word = 32'h00000000;
      endcase
    end
    rd_word = cur_word;
    wr_word = merge_sel(cur_word, wb_dat_i, wb_sel_i);
  end

  // wishbone answer: one cycle after the request, unmapped reads zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // control bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      object_mode_bit_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else if (bus_wr_ok && wb_adr_i == legacy_exec_pkg::OFS_CTRL)
    begin
      object_mode_bit_reg <= wr_word[legacy_exec_pkg::CTRL_OBJECT_MODE_BIT_BIT];
      armed_reg <= wr_word[legacy_exec_pkg::CTRL_ARMED_BIT];
    end
    else if (last_cycle)
    begin
      armed_reg <= 1'b0;
    end
  end

  // pointer select: new value applied after the post-modify
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arp_reg <= 3'h0;
    end
    else if (last_cycle && (arp_load_reg || kind_reg == legacy_exec_pkg::KIND_CALL_IMM))
    begin
      arp_reg <= arp_new_reg;
    end
    else if (bus_wr_ok && wb_adr_i == legacy_exec_pkg::OFS_CTRL)
    begin
      arp_reg <= wr_word[legacy_exec_pkg::CTRL_ARP_LSB +: 3];
    end
  end

  // program counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_reg <= legacy_exec_pkg::PC_RESET;
    end
    else if (last_cycle)
    begin
      pc_reg <= pc_commit;
    end
    else if (bus_wr_ok && wb_adr_i == legacy_exec_pkg::OFS_PC)
    begin
      pc_reg <= wr_word[21:0];
    end
  end

  assign pc_out = pc_reg;

  // stack pointer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp_reg <= legacy_exec_pkg::SP_RESET;
    end
    else if (last_cycle && kind_reg != legacy_exec_pkg::KIND_BANZ)
    begin
      sp_reg <= sp_reg + 16'h0001;
    end
    else if (bus_wr_ok && wb_adr_i == legacy_exec_pkg::OFS_SP)
    begin
      sp_reg <= wr_word[15:0];
    end
  end

  // low accumulator half, software loaded
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_low_reg <= 16'h0000;
    end
    else if (bus_wr_ok && wb_adr_i == legacy_exec_pkg::OFS_ACC_LOW)
    begin
      acc_low_reg <= wr_word[15:0];
    end
  end

  // repeat count: cleared when a legacy transfer follows the prefix
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      repeat_count_reg_reg <= legacy_exec_pkg::REPEAT_COUNT_REG_RESET;
    end
    else if (last_cycle && armed_reg)
    begin
      repeat_count_reg_reg <= legacy_exec_pkg::REPEAT_COUNT_REG_RESET;
    end
    else if (bus_wr_ok && wb_adr_i == legacy_exec_pkg::OFS_REPEAT_COUNT_REG)
    begin
      repeat_count_reg_reg <= wr_word[7:0];
    end
  end

  // sticky unknown-word flag, write one to clear, set wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      unknown_reg <= 1'b0;
    end
    else if (word_take && state_reg == legacy_exec_pkg::ST_IDLE && !dec_hit)
    begin
      unknown_reg <= 1'b1;
    end
    else if (bus_wr && wb_adr_i == legacy_exec_pkg::OFS_STATUS
             && wb_sel_i[0] && wb_dat_i[legacy_exec_pkg::STAT_UNKNOWN_BIT])
    begin
      unknown_reg <= 1'b0;
    end
  end

  aux_reg_file #(
    .COUNT(AUX_COUNT),
    .WIDTH(32)
  ) u_aux (
    .clk(clk),
    .reset_n(reset_n),
    .bus_we(bus_wr_ok && xar_hit),
    .bus_idx(wb_adr_i[4:2]),
    .bus_data(wr_word),
    .mod_en(mod_en),
    .mod_idx(arp_reg),
    .mod_value(xar_mod),
    .regs_flat(xar_flat)
  );
endmodule // legacy_branch_call_exec
`default_nettype wire

// ===== verification/legacy_exec_sva.sv
// port-level checker for the legacy branch and call executor
// assumes it is bound to the executor top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module legacy_exec_sva #(
  parameter int AUX_COUNT = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  input wire logic word_ready,
  input wire logic stack_we,
  input wire logic [15:0] stack_addr,
  input wire logic [15:0] stack_data,
  input wire logic [21:0] pc_out,
  input wire logic exec_done
);
  logic [15:0] ret_lo;
  logic pc_wr;

  // return address of the instruction in flight
  assign ret_lo = pc_out[15:0] + 16'h0001;
  assign pc_wr = wb_cyc_i && wb_we_i && wb_adr_i[7:2] == legacy_exec_pkg::OFS_PC[7:2];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  a_push_single: assert property (stack_we |=> !stack_we)
    else $error("stack push longer than one cycle");
  a_push_ret_addr: assert property (stack_we |-> stack_data == $past(ret_lo))
    else $error("pushed word is not pc plus one");
  a_call_top_page: assert property (stack_we |-> pc_out[21:16] == 6'h3f)
    else $error("call target outside top page");
  a_push_addr_hold: assert property (!stack_we |-> $stable(stack_addr))
    else $error("stack address moved without a push");
  a_done_single: assert property (exec_done |=> !exec_done)
    else $error("done longer than one cycle");
  a_done_after_busy: assert property (exec_done |-> word_ready && !$past(word_ready) && !$past(word_ready, 2))
    else $error("done without two busy cycles before it");
  a_pc_change_cause: assert property ($changed(pc_out) |-> exec_done || $past(pc_wr))
    else $error("pc moved without commit or bus write");
endmodule // legacy_exec_sva
`default_nettype wire

// ===== verification/test_legacy_branch_call_exec.sv
// self-checking bench for the legacy branch and call executor
// assumes the package and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_legacy_branch_call_exec;
  logic clk;
  logic reset_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic word_valid;
  logic [15:0] word_data;
  logic word_ready;
  logic stack_we;
  logic [15:0] stack_addr;
  logic [15:0] stack_data;
  logic [21:0] pc_out;
  logic exec_done;
  logic [31:0] rdat;
  int n_fail;
  int total_checks;
  int n_push;
  int n_done;
  int cyc;
  logic [15:0] ops [10] = '{legacy_exec_pkg::OP_BANZ_IND, legacy_exec_pkg::OP_BANZ_INC,
    legacy_exec_pkg::OP_BANZ_DEC, legacy_exec_pkg::OP_BANZ_IDX_INC,
    legacy_exec_pkg::OP_BANZ_IDX_DEC, legacy_exec_pkg::OP_BANZ_IND_ARP,
    legacy_exec_pkg::OP_BANZ_INC_ARP, legacy_exec_pkg::OP_BANZ_DEC_ARP,
    legacy_exec_pkg::OP_BANZ_IDXI_ARP, legacy_exec_pkg::OP_BANZ_IDXD_ARP};
  logic [31:0] dlt [5] = '{32'h0, 32'h1, 32'hffffffff, 32'h5, 32'hfffffffb};

  legacy_branch_call_exec #(.AUX_COUNT(8)) i_dut (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .word_valid(word_valid),
    .word_data(word_data), .word_ready(word_ready), .stack_we(stack_we),
    .stack_addr(stack_addr), .stack_data(stack_data), .pc_out(pc_out),
    .exec_done(exec_done)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (stack_we === 1'b1)
      n_push++;
    if (exec_done === 1'b1)
      n_done++;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      $display("Error at %0t: bus acknowledge never came", $time);
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask

  task automatic take(input logic [15:0] w);
    int n;
    n = 0;
    word_valid <= 1'b1;
    word_data <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (word_ready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      $display("Error at %0t: instruction word never taken", $time);
    end
  endtask

  // cyc counts edges from the last word taken to done seen
  task automatic run_op(input logic [15:0] op, input logic [15:0] imm, input bit two);
    @(posedge clk);
    take(op);
    if (two)
      take(imm);
    word_valid <= 1'b0;
    word_data <= ~imm;
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
    end
    while (exec_done !== 1'b1 && cyc < 12);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    close_out;
  end

  initial
  begin
    n_fail = 0;
    total_checks = 0;
    n_push = 0;
    n_done = 0;
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    word_valid = 1'b0;
    word_data = 16'h0;
    repeat (10) @(posedge clk);
    chk(32'(pc_out), 32'h003f0000);
    reset_n <= 1'b1;
    xfer(1'b0, legacy_exec_pkg::OFS_SP, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b1, 8'h80, 32'hffffffff);
    xfer(1'b0, 8'h80, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b1, 8'h20, 32'h5);
    for (int i = 0; i < 10; i++)
    begin
      xfer(1'b1, legacy_exec_pkg::OFS_CTRL, 32'h21);
      xfer(1'b1, 8'h28, 32'h00010003);
      run_op(ops[i] | 16'(i < 5 ? 0 : i - 2), 16'h1000 + 16'(i), 1'b1);
      chk(32'(cyc), 32'h5);
      chk(32'(pc_out), 32'h003f1000 + 32'(i));
      xfer(1'b0, 8'h28, 32'h0);
      chk(rdat, 32'h00010003 + dlt[i % 5]);
      xfer(1'b0, legacy_exec_pkg::OFS_CTRL, 32'h0);
      chk(32'(rdat[6:4]), 32'(i < 5 ? 2 : i - 2));
    end
    xfer(1'b1, legacy_exec_pkg::OFS_CTRL, 32'h21);
    xfer(1'b1, 8'h28, 32'h00050000);
    run_op(legacy_exec_pkg::OP_BANZ_DEC, 16'h2222, 1'b1);
    chk(32'(cyc), 32'h3);
    chk(32'(pc_out), 32'h003f100b);
    xfer(1'b0, 8'h28, 32'h0);
    chk(rdat, 32'h0004ffff);
    xfer(1'b1, legacy_exec_pkg::OFS_ACC_LOW, 32'habcd);
    xfer(1'b1, legacy_exec_pkg::OFS_SP, 32'h0100);
    run_op(legacy_exec_pkg::OP_CALL_ACC, 16'h0, 1'b0);
    chk({stack_addr, stack_data}, 32'h0100100c);
    chk(32'(pc_out), 32'h003fabcd);
    run_op(legacy_exec_pkg::OP_CALL_IMM_ARP | 16'h5, 16'h4000, 1'b1);
    chk({stack_addr, stack_data}, 32'h0101abce);
    chk(32'(pc_out), 32'h003f4000);
    xfer(1'b0, legacy_exec_pkg::OFS_CTRL, 32'h0);
    chk(32'(rdat[6:4]), 32'h5);
    xfer(1'b0, legacy_exec_pkg::OFS_SP, 32'h0);
    chk(rdat, 32'h102);
    chk(32'(n_push), 32'h2);
    xfer(1'b1, legacy_exec_pkg::OFS_CTRL, 32'h23);
    xfer(1'b1, legacy_exec_pkg::OFS_REPEAT_COUNT_REG, 32'h7);
    xfer(1'b1, 8'h28, 32'h00010003);
    run_op(legacy_exec_pkg::OP_BANZ_INC, 16'h3000, 1'b1);
    repeat (6) @(posedge clk);
    chk(32'(n_done), 32'd14);
    xfer(1'b0, legacy_exec_pkg::OFS_REPEAT_COUNT_REG, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b0, legacy_exec_pkg::OFS_CTRL, 32'h0);
    chk(32'(rdat[1]), 32'h0);
    xfer(1'b0, 8'h28, 32'h0);
    chk(rdat, 32'h00010004);
    xfer(1'b1, legacy_exec_pkg::OFS_CTRL, 32'h20);
    run_op(legacy_exec_pkg::OP_BANZ_INC, 16'h0, 1'b0);
    chk(32'(pc_out), 32'h003f3000);
    chk(32'(n_done), 32'd14);
    xfer(1'b0, legacy_exec_pkg::OFS_STATUS, 32'h0);
    chk(32'(rdat[2]), 32'h1);
    xfer(1'b1, legacy_exec_pkg::OFS_STATUS, 32'h4);
    xfer(1'b0, legacy_exec_pkg::OFS_STATUS, 32'h0);
    chk(32'(rdat[2]), 32'h0);
    close_out;
  end
endmodule // test_legacy_branch_call_exec

bind legacy_branch_call_exec legacy_exec_sva #(.AUX_COUNT(AUX_COUNT)) i_sva (
  .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .word_valid(word_valid),
  .word_data(word_data), .word_ready(word_ready), .stack_we(stack_we),
  .stack_addr(stack_addr), .stack_data(stack_data), .pc_out(pc_out),
  .exec_done(exec_done)
);
`default_nettype wire
